// File: common/bsl_pkg.sv
// package of constants and types for the boot strap latch
package bsl_pkg;

    // ************************************************************
    // strap vector layout
    // ************************************************************
    localparam int STRAP_W = 3;
    localparam int STRAP_A_POS = 0;
    localparam int STRAP_B_POS = 1;
    localparam int STRAP_C_POS = 2;
    localparam logic [2:0] STRAP_RESET_VAL = 3'h4; // pin c pulled up, others low

    // ************************************************************
    // reset cause vector layout
    // ************************************************************
    localparam int CAUSE_W = 5;
    localparam int CAUSE_POR_POS = 0;
    localparam int CAUSE_RTC_WDT_POS = 1;
    localparam int CAUSE_BROWNOUT_POS = 2;
    localparam int CAUSE_SUPER_WDT_POS = 3;
    localparam int CAUSE_XTAL_GLITCH_POS = 4;

    // ************************************************************
    // print select fuse values
    // ************************************************************
    localparam logic [1:0] PRINT_SEL_ALWAYS = 2'h0;
    localparam logic [1:0] PRINT_SEL_B_LOW = 2'h1;
    localparam logic [1:0] PRINT_SEL_B_HIGH = 2'h2;
    localparam logic [1:0] PRINT_SEL_NEVER = 2'h3;

    // ************************************************************
    // boot modes
    // ************************************************************
    typedef enum logic [1:0] {
        BSL_BOOT_NONE = 2'h0,
        BSL_BOOT_FLASH = 2'h1,
        BSL_BOOT_DOWNLOAD = 2'h3,
        BSL_BOOT_INVALID = 2'h2
    } bsl_boot_t;

    // ************************************************************
    // capture sequencer states, gray coded
    // ************************************************************
    typedef enum logic [1:0] {
        BSL_ST_IDLE = 2'h0,
        BSL_ST_SAMPLE = 2'h1,
        BSL_ST_HELD = 2'h3
    } bsl_state_t;

endpackage

// File: hw/bsl_pad_pull.sv
// weak internal pull resolution for the three strap pads
`timescale 1ns/10ps
module bsl_pad_pull (
    input wire logic [2:0] pad_in,
    input wire logic [2:0] pad_oe,
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_driven,
    output logic [2:0] pad_level
);
    // ************************************************************
    // per pad level
    // ************************************************************
    // an undriven pad settles at its pull level, pin c pulls high
    genvar i;
    for (i = 0; i < bsl_pkg::STRAP_W; i++) begin : g_pad
        always_comb begin
            if (pad_oe[i]) begin
                pad_level[i] = pad_out[i];
            end else if (pad_driven[i]) begin
                pad_level[i] = pad_in[i];
            end else begin
                pad_level[i] = bsl_pkg::STRAP_RESET_VAL[i];
            end
        end
    end
endmodule

// File: hw/bsl_boot_decode.sv
// boot mode and print enable decoder
`timescale 1ns/10ps
module bsl_boot_decode (
    input wire logic [2:0] strap,
    input wire logic [1:0] print_sel,
    output bsl_pkg::bsl_boot_t boot_mode,
    output logic print_en,
    output logic invalid
);
    logic pin_a;
    logic pin_b;
    logic pin_c;
    assign pin_a = strap[bsl_pkg::STRAP_A_POS];
    assign pin_b = strap[bsl_pkg::STRAP_B_POS];
    assign pin_c = strap[bsl_pkg::STRAP_C_POS];

    // ************************************************************
    // boot mode
    // ************************************************************
    // the b low, c low combination is flagged rather than guessed
    always_comb begin
        invalid = !pin_b && !pin_c;
        if (invalid) begin
            boot_mode = bsl_pkg::BSL_BOOT_INVALID;
        end else if (pin_a && pin_c) begin
            boot_mode = bsl_pkg::BSL_BOOT_FLASH;
        end else if (pin_a && pin_b && !pin_c) begin
            boot_mode = bsl_pkg::BSL_BOOT_DOWNLOAD;
        end else begin
            boot_mode = bsl_pkg::BSL_BOOT_NONE;
        end
    end

    // ************************************************************
    // print enable
    // ************************************************************
    always_comb begin
        case (print_sel)
            bsl_pkg::PRINT_SEL_ALWAYS: print_en = 1'b1;
            bsl_pkg::PRINT_SEL_B_LOW: print_en = !pin_b;
            bsl_pkg::PRINT_SEL_B_HIGH: print_en = pin_b;
            default: print_en = 1'b0;
        endcase
    end
endmodule

// File: hw/bsl_boot_strap_latch.sv
// boot strap latch top: captures strap pins on system reset release
`timescale 1ns/10ps
module bsl_boot_strap_latch (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] reset_cause,
    input wire logic [1:0] print_select_fuse,
    input wire logic strap_pin_a_in,
    input wire logic strap_pin_b_in,
    input wire logic strap_pin_c_in,
    input wire logic [2:0] strap_pad_driven,
    input wire logic [2:0] func_out,
    input wire logic [2:0] func_oe,
    output logic strap_pin_a_out,
    output logic strap_pin_b_out,
    output logic strap_pin_c_out,
    output logic strap_pin_a_oe,
    output logic strap_pin_b_oe,
    output logic strap_pin_c_oe,
    output logic [2:0] func_in,
    output logic [2:0] strap_status_register,
    output logic [1:0] boot_mode,
    output logic boot_print_en,
    output logic strap_invalid,
    output logic strap_valid
);
    // ************************************************************
    // declarations
    // ************************************************************
    bsl_pkg::bsl_state_t state_ff;
    bsl_pkg::bsl_state_t nxt_state;
    logic [2:0] strap_ff;
    logic [2:0] pad_level;
    logic [2:0] pad_oe_ff;
    logic [2:0] pad_out_ff;
    logic [2:0] func_in_ff;
    logic [1:0] boot_mode_ff;
    logic print_en_ff;
    logic invalid_ff;
    logic valid_ff;
    logic sys_cause;
    logic pin_mode_ff;
    bsl_pkg::bsl_boot_t dec_mode;
    logic dec_print;
    logic dec_invalid;

    // any of the system reset causes asks for a fresh capture
    assign sys_cause = |reset_cause;

    // ************************************************************
    // pad level with weak pulls
    // ************************************************************
    bsl_pad_pull u_pull (
        .pad_in({strap_pin_c_in, strap_pin_b_in, strap_pin_a_in}),
        .pad_oe(pad_oe_ff),
        .pad_out(pad_out_ff),
        .pad_driven(strap_pad_driven),
        .pad_level(pad_level)
    );

    // ************************************************************
    // capture sequencer
    // ************************************************************
    // sample waits in reset, takes the pins once on release, then holds
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bsl_pkg::BSL_ST_IDLE: nxt_state = bsl_pkg::BSL_ST_SAMPLE;
            bsl_pkg::BSL_ST_SAMPLE: nxt_state = bsl_pkg::BSL_ST_HELD;
            bsl_pkg::BSL_ST_HELD: begin
                if (sys_cause) begin
                    nxt_state = bsl_pkg::BSL_ST_SAMPLE;
                end
            end
            default: nxt_state = bsl_pkg::BSL_ST_IDLE;
        endcase
    end

    // state register, asynchronous reset is the power-on system reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= bsl_pkg::BSL_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // strap latches
    // ************************************************************
    // only the sample state writes; non-system resets leave the bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_ff <= bsl_pkg::STRAP_RESET_VAL;
        end else if (state_ff == bsl_pkg::BSL_ST_SAMPLE) begin
            strap_ff <= pad_level;
        end
    end

    // pins are strap inputs until the latches hold
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_mode_ff <= 1'b0;
        end else begin
            pin_mode_ff <= (nxt_state == bsl_pkg::BSL_ST_HELD);
        end
    end

    // ************************************************************
    // pad drive
    // ************************************************************
    // strap duty keeps the pads undriven, later the function logic owns them
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pad_oe_ff <= 3'h0;
            pad_out_ff <= 3'h0;
        end else if (nxt_state == bsl_pkg::BSL_ST_HELD) begin
            pad_oe_ff <= func_oe;
            pad_out_ff <= func_out;
        end else begin
            pad_oe_ff <= 3'h0;
            pad_out_ff <= 3'h0;
        end
    end

    // function input path follows the pad in normal use
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            func_in_ff <= 3'h0;
        end else if (pin_mode_ff) begin
            func_in_ff <= pad_level;
        end else begin
            func_in_ff <= 3'h0;
        end
    end

    // ************************************************************
    // decode of latched straps
    // ************************************************************
    bsl_boot_decode u_dec (
        .strap(strap_ff),
        .print_sel(print_select_fuse),
        .boot_mode(dec_mode),
        .print_en(dec_print),
        .invalid(dec_invalid)
    );

    // registered decode outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_mode_ff <= bsl_pkg::BSL_BOOT_NONE;
            print_en_ff <= 1'b0;
            invalid_ff <= 1'b0;
        end else begin
            boot_mode_ff <= dec_mode;
            print_en_ff <= dec_print && (dec_mode == bsl_pkg::BSL_BOOT_FLASH);
            invalid_ff <= dec_invalid && pin_mode_ff;
        end
    end

    // valid once a capture has been taken and decoded
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= pin_mode_ff;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign strap_status_register = strap_ff;
    assign strap_pin_a_out = pad_out_ff[bsl_pkg::STRAP_A_POS];
    assign strap_pin_b_out = pad_out_ff[bsl_pkg::STRAP_B_POS];
    assign strap_pin_c_out = pad_out_ff[bsl_pkg::STRAP_C_POS];
    assign strap_pin_a_oe = pad_oe_ff[bsl_pkg::STRAP_A_POS];
    assign strap_pin_b_oe = pad_oe_ff[bsl_pkg::STRAP_B_POS];
    assign strap_pin_c_oe = pad_oe_ff[bsl_pkg::STRAP_C_POS];
    assign func_in = func_in_ff;
    assign boot_mode = boot_mode_ff;
    assign boot_print_en = print_en_ff;
    assign strap_invalid = invalid_ff;
    assign strap_valid = valid_ff;
endmodule

// File: verification/bsl_boot_strap_latch_chk.sv
// assertion checker for the boot strap latch ports
`timescale 1ns/10ps
module bsl_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] reset_cause,
    input wire logic [1:0] print_select_fuse,
    input wire logic strap_pin_a_in,
    input wire logic strap_pin_b_in,
    input wire logic strap_pin_c_in,
    input wire logic [2:0] strap_pad_driven,
    input wire logic [2:0] func_oe,
    input wire logic strap_pin_a_oe,
    input wire logic strap_pin_b_oe,
    input wire logic strap_pin_c_oe,
    input wire logic [2:0] strap_status_register,
    input wire logic [1:0] boot_mode,
    input wire logic boot_print_en,
    input wire logic strap_invalid,
    input wire logic strap_valid
);
    // ************************************************************
    // helpers and properties
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [2:0] lvl;
    logic [2:0] ss;
    logic [1:0] f;
    logic p_exp;
    // pad level as the latch should see it, floating pads at their pulls
    assign lvl = {strap_pad_driven[2] ? strap_pin_c_in : 1'b1,
                  strap_pad_driven[1] & strap_pin_b_in, strap_pad_driven[0] & strap_pin_a_in};
    assign ss = strap_status_register;
    assign f = print_select_fuse;
    assign p_exp = f == 2'h0 || (f == 2'h1 && !ss[1]) || (f == 2'h2 && ss[1]);
    a_hold_latched: assert property (strap_valid && reset_cause == 5'h0
        && $past(reset_cause) == 5'h0 |=> $stable(ss)) else $error("latched straps moved");
    a_reset_quiet: assert property ($fell(rst) |-> ss == bsl_pkg::STRAP_RESET_VAL
        && !strap_valid && {strap_pin_c_oe, strap_pin_b_oe, strap_pin_a_oe} == 3'h0)
        else $error("reset state");
    a_capture_release: assert property ($fell(rst) |-> ##2 ss == $past(lvl)
        ##[1:2] strap_valid) else $error("capture at reset release");
    // the cause is seen at one edge, the latch loads at the next one and is checked at the second
    a_capture_cause: assert property (strap_valid && reset_cause != 5'h0
        |-> ##2 ss == $past(lvl)) else $error("capture on reset cause");
    a_flash_decode: assert property (strap_valid && $stable(ss) && ss[0] && ss[2]
        |-> boot_mode == bsl_pkg::BSL_BOOT_FLASH) else $error("flash decode");
    a_dl_decode: assert property (strap_valid && $stable(ss) && ss == 3'h3
        |-> boot_mode == bsl_pkg::BSL_BOOT_DOWNLOAD) else $error("download decode");
    a_invalid_mode: assert property (strap_valid && $stable(ss) && ss[2:1] == 2'h0
        |-> boot_mode == bsl_pkg::BSL_BOOT_INVALID) else $error("invalid mode");
    a_print_fuse: assert property (strap_valid && $stable(ss) && $stable(f)
        && ss[0] && ss[2] |-> boot_print_en == p_exp) else $error("print select");
    a_print_off: assert property (strap_valid && $stable(ss) && !(ss[0] && ss[2])
        |-> !boot_print_en) else $error("print outside flash boot");
    a_invalid_flag: assert property (strap_valid && $stable(ss)
        |-> strap_invalid == (ss[2:1] == 2'h0)) else $error("invalid flag");
    a_oe_follow: assert property (strap_valid && reset_cause == 5'h0
        && $past(reset_cause) == 5'h0 && $past(reset_cause, 2) == 5'h0
        |-> {strap_pin_c_oe, strap_pin_b_oe, strap_pin_a_oe} == $past(func_oe))
        else $error("pads not released");
    c_flash: cover property (strap_valid && boot_mode == bsl_pkg::BSL_BOOT_FLASH);
    c_download: cover property (strap_valid && boot_mode == bsl_pkg::BSL_BOOT_DOWNLOAD);
    c_invalid: cover property (strap_valid && strap_invalid);
    c_print: cover property (strap_valid && boot_print_en);
endmodule

// File: verification/bsl_board.sv
// board model: host outputs, device outputs or a wandering level on the strap pads
`timescale 1ns/10ps
module bsl_board (
    input wire logic clock,
    input wire logic [2:0] want,
    input wire logic [2:0] drv,
    input wire logic [2:0] dev_oe,
    input wire logic [2:0] dev_out,
    output logic [2:0] pad,
    output logic [2:0] pad_driven
);
    logic [2:0] wobble_ff = 3'h2;
    // released pad b toggles and pads a and c sit low, so a stale level never reads as a strap
    always_ff @(posedge clock) begin
        wobble_ff <= ~wobble_ff ^ 3'h5;
    end
    // host drive wins, then the device, else the wandering level
    assign pad = (drv & want) | (~drv & dev_oe & dev_out) | (~drv & ~dev_oe & wobble_ff);
    assign pad_driven = drv;
endmodule

// File: verification/test_boot_strap_latch.sv
// self-checking bench for the boot strap latch
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_boot_strap_latch;
    logic clock = 0, rst = 1;
    logic [4:0] reset_cause = 0;
    logic [1:0] print_select_fuse = 0, boot_mode, f;
    logic [2:0] func_out = 0, func_oe = 0, want = 0, drv = 0, pad, strap_pad_driven, func_in;
    logic [2:0] strap_status_register, w, d, s;
    logic strap_pin_a_in, strap_pin_b_in, strap_pin_c_in, strap_pin_a_out, strap_pin_b_out;
    logic strap_pin_c_out, strap_pin_a_oe, strap_pin_b_oe, strap_pin_c_oe;
    logic boot_print_en, strap_invalid, strap_valid;
    logic [31:0] seed = 32'h53;
    int bad_count = 0, n_checks = 0, cyc = 0;
    localparam int CE_LOW_CYC = 12500; // 50 us of chip enable low at 4 ns a cycle
    localparam int TIMEOUT_CYC = 60000; // four long chip enable pulses plus the short tests
    assign {strap_pin_c_in, strap_pin_b_in, strap_pin_a_in} = pad;
    bsl_boot_strap_latch DUT (.*);
    bsl_board board (.clock(clock), .want(want), .drv(drv), .pad(pad), .pad_driven(strap_pad_driven),
        .dev_oe({strap_pin_c_oe, strap_pin_b_oe, strap_pin_a_oe}),
        .dev_out({strap_pin_c_out, strap_pin_b_out, strap_pin_a_out}));
    // ************************************************************
    // expectation helpers
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic exp_pen(input logic [2:0] v, input logic [1:0] g);
        if (!(v[0] && v[2])) return 1'b0;
        return g == 2'h0 || (g == 2'h1 && !v[1]) || (g == 2'h2 && v[1]);
    endfunction
    // pad level seen by the function logic: own drive, host drive, else the pull
    function automatic logic [2:0] exp_fin(input logic [2:0] oe, input logic [2:0] out,
        input logic [2:0] dv, input logic [2:0] wt);
        return (oe & out) | (~oe & dv & wt) | (~oe & ~dv & bsl_pkg::STRAP_RESET_VAL);
    endfunction
    task check_out;
        logic [1:0] m;
        m = (s[2:1] == 2'h0) ? bsl_pkg::BSL_BOOT_INVALID : (s[0] && s[2]) ? bsl_pkg::BSL_BOOT_FLASH
            : (s == 3'h3) ? bsl_pkg::BSL_BOOT_DOWNLOAD : bsl_pkg::BSL_BOOT_NONE;
        `CHK("straps", s, strap_status_register)
        `CHK("mode", m, boot_mode)
        `CHK("print", exp_pen(s, f), boot_print_en)
        `CHK("invalid", s[2:1] == 2'h0, strap_invalid)
        `CHK("valid", 1'h1, strap_valid)
        `CHK("pad oe", func_oe, {strap_pin_c_oe, strap_pin_b_oe, strap_pin_a_oe})
        `CHK("pad out", func_out, {strap_pin_c_out, strap_pin_b_out, strap_pin_a_out})
        `CHK("func in", exp_fin(func_oe, func_out, drv, want), func_in)
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    initial forever #2 clock = ~clock;
    // cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == TIMEOUT_CYC) begin
            bad_count++;
            give_verdict;
        end
    end
    // random straps and fuses, captured by every reset source in turn
    initial begin
        // reset stays on into the first long chip enable pulse below
        repeat (12) @(posedge clock);
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            {f, d, w} = seed[7:0];
            if (i == 0) d = 3'h0;
            s = {d[2] ? w[2] : 1'b1, d[1] & w[1], d[0] & w[0]};
            if (i != 1 && s[2:1] == 2'h0) begin
                {d[2], w[2], s[2]} = 3'h7;
            end
            if (i == 1) {d, w, s} = 9'h180;
            @(posedge clock);
            want <= w;
            drv <= d;
            print_select_fuse <= f;
            {func_out, func_oe} <= seed[13:8];
            if (i % 6 == 0) rst <= 1;
            else reset_cause <= 5'h1 << (i % 6 - 1);
            if (i % 6 == 0) repeat (CE_LOW_CYC) @(posedge clock);
            else @(posedge clock);
            rst <= 0;
            reset_cause <= 5'h0;
            repeat (6) @(posedge clock);
            #1 check_out;
            @(posedge clock);
            want <= ~w;
            drv <= 3'h7;
            repeat (4) @(posedge clock);
            #1 check_out;
            $display("test %0d done", i);
        end
        give_verdict;
    end
endmodule
bind bsl_boot_strap_latch bsl_chk u_chk (.*);
